// File: logic/lcoc_top.sv
// Purpose: Output control for a nine-channel LED current driver
// Assumes: APB slave on the system clock, engines on the same clock
// Notes: Temperature reading arrives from another domain and is synchronised
//
// Operation
// R1: Nine software on/off bits, two registers
// R2: Engine selection overrides software on/off bit
// R3: Bits 7:6 choose no fader or fader 1-3
// R4: Faded duty is PWM value times fader
// R5: Bit 5 selects linear or logarithmic scaling
// R6: Logarithmic mode uses 12-bit internal duty
// R7: Set duty comes from nine PWM registers
// R8: Final duty halves set minus temperature term
// R9: Five-bit signed slope in 0.1 steps
// R10: Slope field 5'h00 disables compensation entirely; 5'h10 still halves
// R11: Any engine loading freezes all PWM outputs
// R12: Compensation follows each temperature reading change

`timescale 1ns/1ps

module lcoc_top
  import lcoc_pkg::*;
#(
  parameter int CHANNELS = NUM_CHAN
)
(
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [APB_AW-1:0] i_paddr,
  input wire logic [APB_DW-1:0] i_pwdata,
  output logic [APB_DW-1:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire lcoc_engine_type i_engine,
  input wire logic [NUM_FADER-1:0] i_engine_loading,
  input wire logic [NUM_FADER-1:0][DUTY_W-1:0] i_fader_value,
  input wire logic [TEMP_W-1:0] i_temp_reading,
  output logic [CHANNELS-1:0] o_chan_on,
  output logic [CHANNELS-1:0][FINE_W-1:0] o_final_duty,
  output logic o_pwm_frozen
);

  // ****************************************
  // Declarations
  // ****************************************
  logic [CHANNELS-1:0] chan_enable;
  lcoc_cfg_type [CHANNELS-1:0] chan_cfg;
  logic [CHANNELS-1:0][DUTY_W-1:0] chan_duty_value;
  logic [TEMP_W-1:0] temp_meta;
  logic signed [TEMP_W-1:0] temp_sync;
  logic [CHANNELS-1:0][FINE_W-1:0] next_final_duty;
  logic [5:0] bus_index;
  logic setup_phase;
  logic write_strobe;
  logic [REG_W-1:0] wr_byte;
  logic [REG_W-1:0] next_rdata;
  logic next_slverr;
  logic any_loading;

  // ****************************************
  // Address decode helpers
  // ****************************************

  // True when the index falls in a block of one register per channel
  function automatic logic in_bank(input logic [5:0] idx, input logic [5:0] base);
    logic [5:0] off;
    off = idx - base;
    return (idx >= base) && (off < 6'(CHANNELS));
  endfunction

  // Channel number within a bank; only meaningful when in_bank holds
  function automatic logic [5:0] bank_chan(input logic [5:0] idx, input logic [5:0] base);
    return idx - base;
  endfunction

  // ****************************************
  // APB slave signalling
  // ****************************************
  // Word index from the byte address; low two bits are ignored
  assign bus_index = i_paddr[7:2];
  assign setup_phase = i_psel && !i_penable;
  // Writes take effect in the access phase, which always completes at once
  assign write_strobe = i_psel && i_penable && i_pwrite;
  assign wr_byte = i_pwdata[REG_W-1:0];
  // Read data is captured in the setup cycle so the access phase is one cycle
  assign o_pready = i_psel && i_penable;

  // ****************************************
  // Software on/off register pair
  // ****************************************
  // Ninth output lives alone in the upper register
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      chan_enable <= '0;
    end else if (write_strobe && bus_index == IDX_EN_UPPER) begin
      chan_enable[CHANNELS-1] <= wr_byte[UPPER_EN_BIT]; // see R1
    end else if (write_strobe && bus_index == IDX_EN_LOWER) begin
      chan_enable[REG_W-1:0] <= wr_byte; // see R1
    end
  end

  // ****************************************
  // Channel configuration registers
  // ****************************************
  // Fader group, scaling mode and slope share one byte per channel
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      for (int i = 0; i < CHANNELS; i++) begin
        chan_cfg[i] <= RST_CFG;
      end
    end else if (write_strobe && in_bank(bus_index, IDX_CFG_BASE)) begin
      chan_cfg[bank_chan(bus_index, IDX_CFG_BASE)] <= wr_byte; // see R3 see R5 see R9
    end
  end

  // ****************************************
  // Set duty registers
  // ****************************************
  // One set duty byte per output
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      for (int i = 0; i < CHANNELS; i++) begin
        chan_duty_value[i] <= RST_DUTY;
      end
    end else if (write_strobe && in_bank(bus_index, IDX_DUTY_BASE)) begin
      chan_duty_value[bank_chan(bus_index, IDX_DUTY_BASE)] <= wr_byte; // see R7
    end
  end

  // ****************************************
  // Temperature synchroniser
  // ****************************************
  // Sensor updates slowly; a torn multi-bit sample lasts one cycle at most
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      temp_meta <= '0;
      temp_sync <= '0;
    end else begin
      temp_meta <= i_temp_reading;
      temp_sync <= temp_meta; // see R12
    end
  end

  // ****************************************
  // Duty computation per channel
  // ****************************************
  // One arithmetic slice per output; all share the fader and temperature
  for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_chan
    lcoc_duty_calc u_calc (
      .i_cfg(chan_cfg[ch]),
      .i_set_duty(chan_duty_value[ch]),
      .i_fader_value(i_fader_value),
      .i_temp(temp_sync),
      .o_final_duty(next_final_duty[ch])
    );
  end

  // ****************************************
  // Program load freeze
  // ****************************************
  // Any single engine in load mode holds every final duty output
  assign any_loading = |i_engine_loading;

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_pwm_frozen <= 1'b0;
    end else begin
      o_pwm_frozen <= any_loading; // see R11
    end
  end

  // ****************************************
  // Final duty outputs
  // ****************************************
  // Reloaded each cycle no engine is loading; a new setting shows next edge, a new reading three edges later
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_final_duty <= '0;
    end else if (!any_loading) begin
      o_final_duty <= next_final_duty; // see R11 see R12
    end
  end

  // ****************************************
  // Effective on/off state
  // ****************************************
  // Engine choice wins per channel; software bits stay stored untouched
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_chan_on <= '0;
    end else begin
      for (int i = 0; i < CHANNELS; i++) begin
        o_chan_on[i] <= i_engine.select[i] ? i_engine.turn_on[i] : chan_enable[i]; // see R2
      end
    end
  end

  // ****************************************
  // Read data mux
  // ****************************************
  // Unmapped indices read zero and flag an error response
  always_comb begin
    next_rdata = '0;
    next_slverr = 1'b0;
    if (bus_index == IDX_EN_UPPER) begin
      next_rdata[UPPER_EN_BIT] = chan_enable[CHANNELS-1];
    end else if (bus_index == IDX_EN_LOWER) begin
      next_rdata = chan_enable[REG_W-1:0];
    end else if (in_bank(bus_index, IDX_CFG_BASE)) begin
      next_rdata = chan_cfg[bank_chan(bus_index, IDX_CFG_BASE)];
    end else if (in_bank(bus_index, IDX_DUTY_BASE)) begin
      next_rdata = chan_duty_value[bank_chan(bus_index, IDX_DUTY_BASE)];
    end else if (bus_index == IDX_STAT_LOWER) begin
      next_rdata = o_chan_on[REG_W-1:0];
    end else if (bus_index == IDX_STAT_UPPER) begin
      next_rdata[UPPER_EN_BIT] = o_chan_on[CHANNELS-1];
      next_rdata[FREEZE_BIT] = o_pwm_frozen;
    end else if (bus_index == IDX_TEMP) begin
      next_rdata = temp_sync;
    end else begin
      next_slverr = 1'b1;
    end
  end

  // ****************************************
  // Read data and error capture
  // ****************************************
  // Captured in setup so data and error come straight from flops
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_prdata <= '0;
      o_pslverr <= 1'b0;
    end else if (setup_phase) begin
      o_prdata <= {{(APB_DW-REG_W){1'b0}}, next_rdata};
      o_pslverr <= next_slverr;
    end
  end

endmodule // lcoc_top

// File: logic/lcoc_pkg.sv
// Purpose: Shared constants and types for the LED channel output control block
// Assumes: Registers are 8 bits wide, one per word index on the APB bus
// Notes: Byte address of a register is four times its index

package lcoc_pkg;

  // ****************************************
  // Geometry
  // ****************************************
  localparam int NUM_CHAN = 9;
  localparam int REG_W = 8;
  localparam int DUTY_W = 8;
  localparam int FINE_W = 12;
  localparam int NUM_FADER = 3;
  localparam int TEMP_W = 8;
  localparam int APB_AW = 8;
  localparam int APB_DW = 32;

  // ****************************************
  // Register indices (byte address = index * 4)
  // ****************************************
  localparam logic [5:0] IDX_EN_UPPER = 6'h04;
  localparam logic [5:0] IDX_EN_LOWER = 6'h05;
  localparam logic [5:0] IDX_CFG_BASE = 6'h06;
  localparam logic [5:0] IDX_DUTY_BASE = 6'h16;
  localparam logic [5:0] IDX_STAT_LOWER = 6'h20;
  localparam logic [5:0] IDX_STAT_UPPER = 6'h21;
  localparam logic [5:0] IDX_TEMP = 6'h22;

  // ****************************************
  // Reset values and field codes
  // ****************************************
  localparam logic [7:0] RST_EN = 8'h00;
  localparam logic [7:0] RST_CFG = 8'h00;
  localparam logic [7:0] RST_DUTY = 8'h00;
  localparam logic [1:0] FADER_NONE = 2'h0;
  localparam logic [4:0] SLOPE_OFF = 5'h00;
  localparam int UPPER_EN_BIT = 0;
  localparam int FREEZE_BIT = 1;
  localparam int LOG_SHIFT = 4;

  // ****************************************
  // Temperature compensation
  // ****************************************
  localparam int TEMP_REF_C = 25;
  // Slope is in tenths and the product is taken in percent of duty
  localparam int SLOPE_SCALE = 1000;
  localparam int FINE_MAX = (1 << FINE_W) - 1;

  // Channel configuration byte, same bit layout as the register
  typedef struct packed {
    logic [1:0] fader_select;
    logic log_scale;
    logic [4:0] temp_slope;
  } lcoc_cfg_type;

  // Engine request for one channel set
  typedef struct packed {
    logic [NUM_CHAN-1:0] select;
    logic [NUM_CHAN-1:0] turn_on;
  } lcoc_engine_type;

endpackage

// File: logic/lcoc_duty_calc.sv
// Purpose: Duty cycle arithmetic for one output channel
// Assumes: All inputs are stable flops of the system clock domain
// Notes: Purely combinational; the caller registers the result

`timescale 1ns/1ps

module lcoc_duty_calc
  import lcoc_pkg::*;
(
  input wire lcoc_cfg_type i_cfg,
  input wire logic [DUTY_W-1:0] i_set_duty,
  input wire logic [NUM_FADER-1:0][DUTY_W-1:0] i_fader_value,
  input wire logic signed [TEMP_W-1:0] i_temp,
  output logic [FINE_W-1:0] o_final_duty
);

  logic [DUTY_W-1:0] faded;
  logic [2*DUTY_W-1:0] fader_product;
  logic [2*DUTY_W-1:0] log_square;
  logic [FINE_W-1:0] set_fine;

  // ****************************************
  // Fader scaling
  // ****************************************
  // Product keeps the upper byte so full scale stays close to full scale
  always_comb begin
    fader_product = '0;
    if (i_cfg.fader_select != FADER_NONE) begin
      fader_product = i_set_duty * i_fader_value[i_cfg.fader_select - 2'h1]; // see R3 see R4
    end
    faded = (i_cfg.fader_select == FADER_NONE) ? i_set_duty : fader_product[2*DUTY_W-1:DUTY_W];
  end

  // ****************************************
  // Linear or logarithmic scaling
  // ****************************************
  // Square law gives fine steps at low duty at 12-bit resolution
  always_comb begin
    log_square = faded * faded;
    if (i_cfg.log_scale) begin
      set_fine = log_square[2*DUTY_W-1:LOG_SHIFT]; // see R5 see R6
    end else begin
      set_fine = {faded, {(FINE_W-DUTY_W){1'b0}}}; // see R5
    end
  end

  // ****************************************
  // Temperature compensation
  // ****************************************
  // Negative results clamp to zero, overflow clamps to full scale
  always_comb begin
    int slope;
    int delta_t;
    int term;
    int result;
    // Slope is sign and magnitude, not two's complement: top bit negates tenths
    slope = int'(i_cfg.temp_slope[3:0]);
    if (i_cfg.temp_slope[4]) begin
      slope = -slope; // see R9
    end
    delta_t = TEMP_REF_C - int'(i_temp);
    term = (delta_t * slope * int'(set_fine)) / SLOPE_SCALE;
    result = (int'(set_fine) - term) / 2; // see R8
    if (i_cfg.temp_slope == SLOPE_OFF) begin
      o_final_duty = set_fine; // see R10
    end else if (result < 0) begin
      o_final_duty = '0;
    end else if (result > FINE_MAX) begin
      o_final_duty = FINE_W'(FINE_MAX);
    end else begin
      o_final_duty = result[FINE_W-1:0];
    end
  end

endmodule // lcoc_duty_calc

// File: verif/lcoc_top_chk.sv
// Purpose: Port assertions for the LED channel output control block
// Assumes: One clock domain, asynchronous active-low reset
// Notes: A shadow of register writes predicts read data and plain duty
`timescale 1ns/1ps
module lcoc_top_chk
  import lcoc_pkg::*;
#(parameter int CHANNELS = NUM_CHAN)
(
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [APB_AW-1:0] i_paddr,
  input wire logic [APB_DW-1:0] i_pwdata,
  input wire logic [APB_DW-1:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire lcoc_engine_type i_engine,
  input wire logic [NUM_FADER-1:0] i_engine_loading,
  input wire logic [CHANNELS-1:0] o_chan_on,
  input wire logic [CHANNELS-1:0][FINE_W-1:0] o_final_duty,
  input wire logic o_pwm_frozen
);
  // ****************************************
  // Helpers
  // ****************************************
  logic [7:0] sh [64];
  logic ok1;
  logic [FINE_W-1:0] exp1;
  wire [5:0] idx = i_paddr[7:2];
  wire acc = i_psel && i_penable;
  wire rw = (idx >= 6'h04 && idx <= 6'h0E) || (idx >= 6'h16 && idx <= 6'h1E);
  wire mapped = rw || (idx >= 6'h20 && idx <= 6'h22);
  wire [8:0] en = {sh[4][0], sh[5]};

  // Shadow of writes; upper enable keeps bit 0 only
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      for (int k = 0; k < 64; k++) sh[k] <= 8'h00;
    end else if (acc && i_pwrite && rw) begin
      sh[idx] <= (idx == 6'h04) ? (i_pwdata[7:0] & 8'h01) : i_pwdata[7:0];
    end
  end

  // Channel one duty when no fader, scaling or freeze applies
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      ok1 <= 1'b0;
      exp1 <= 12'h000;
    end else begin
      ok1 <= (sh[6] == 8'h00) && !(|i_engine_loading);
      exp1 <= {sh[22], 4'h0};
    end
  end

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);

  AST_PREADY: assert property (o_pready == acc)
    else $error("pready differs from psel and penable");
  AST_UNMAPPED: assert property (acc && !mapped |-> o_pslverr && o_prdata == 32'h0)
    else $error("unmapped access not refused");
  AST_READBACK: assert property (acc && !i_pwrite && rw |-> o_prdata == {24'h0, sh[idx]})
    else $error("read data differs from last write");
  AST_CHAN_SW: assert property ($past(i_resetn) |->
    ((o_chan_on ^ $past(en)) & ~$past(i_engine.select)) == 9'h0)
    else $error("unselected output ignores its enable");
  AST_CHAN_ENG: assert property ($past(i_resetn) |->
    ((o_chan_on ^ $past(i_engine.turn_on)) & $past(i_engine.select)) == 9'h0)
    else $error("engine selection not obeyed");
  AST_FREEZE_HOLD: assert property ($past(i_resetn) && (|$past(i_engine_loading)) |->
    $stable(o_final_duty))
    else $error("duty moved while loading");
  AST_FROZEN_FLAG: assert property ($past(i_resetn) |->
    o_pwm_frozen == (|$past(i_engine_loading)))
    else $error("frozen flag wrong");
  AST_DUTY_PLAIN: assert property (ok1 |-> o_final_duty[0] == exp1)
    else $error("plain duty differs from duty register");

  CVR_WRITE: cover property (acc && i_pwrite);
  CVR_FROZEN: cover property (o_pwm_frozen);
  CVR_ENGINE: cover property (|(i_engine.select & o_chan_on));
endmodule // lcoc_top_chk

bind lcoc_top lcoc_top_chk #(.CHANNELS(CHANNELS)) u_chk (.i_clk_sys, .i_resetn, .i_psel,
  .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .i_engine,
  .i_engine_loading, .o_chan_on, .o_final_duty, .o_pwm_frozen);

// File: verif/lcoc_test.sv
// Purpose: Self-checking bench for the LED channel output control block
// Assumes: Zero wait state slave, duty settles within five edges
// Notes: Duty cases run on channel one only to keep the run short
`timescale 1ns/1ps
module lcoc_test;
  // ****************************************
  // Stimulus and checks
  // ****************************************
  logic clk = 1'b0, rstn = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic [7:0] paddr = 8'h00, temp = 8'h19;
  logic [31:0] pwdata = 32'h0, rdata, prdata;
  logic [17:0] eng = 18'h0;
  logic [2:0] load = 3'h0;
  logic [23:0] fader = 24'hC08040;
  logic pready, pslverr, rerr, frozen;
  logic [8:0] chan_on;
  logic [107:0] fduty;
  int errors = 0, tests_run = 0;
  // Config, temperature and expected duty for each case
  logic [7:0] cfg_t [11] = '{8'h00, 8'h40, 8'h80, 8'hC0, 8'h20, 8'h0F, 8'h0F, 8'h0E,
    8'h1F, 8'h1E, 8'h00};
  logic [7:0] tmp_t [11] = '{8'h19, 8'h19, 8'h19, 8'h19, 8'h19, 8'h19, 8'hF6, 8'hF6,
    8'hF6, 8'hF6, 8'hF6};
  logic [11:0] exp_t [11] = '{12'h800, 12'h200, 12'h400, 12'h600, 12'h400, 12'h400,
    12'h1E6, 12'h20A, 12'h619, 12'h5F5, 12'h800};

  lcoc_top dut (.i_clk_sys(clk), .i_resetn(rstn), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_engine(eng), .i_engine_loading(load),
    .i_fader_value(fader), .i_temp_reading(temp), .o_chan_on(chan_on),
    .o_final_duty(fduty), .o_pwm_frozen(frozen));

  initial forever #20 clk = ~clk;

  task automatic results();
    $display("Checks %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One bus transfer; a bounded wait guards against a missing pready
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      errors++;
      results();
    end
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  initial begin
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    for (int a = 16; a <= 24; a += 4) begin
      xfer(1'b0, 8'(a), 32'h0);
      chk("reset value", 32'h0, rdata);
    end
    xfer(1'b1, 8'h10, 32'h0000_00FF);
    xfer(1'b1, 8'h14, 32'hFFFF_FFA5);
    xfer(1'b0, 8'h10, 32'h0);
    chk("upper enable", 32'h1, rdata);
    xfer(1'b0, 8'h14, 32'h0);
    chk("lower enable", 32'hA5, rdata);
    repeat (2) @(posedge clk);
    chk("chan on", 32'h1A5, {23'h0, chan_on});
    eng <= {9'h003, 9'h002};
    repeat (3) @(posedge clk);
    chk("engine override", 32'h1A6, {23'h0, chan_on});
    eng <= 18'h0;
    xfer(1'b0, 8'h40, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, rerr});
    chk("unmapped data", 32'h0, rdata);
    xfer(1'b1, 8'h58, 32'h80);
    for (int k = 0; k < 11; k++) begin
      temp <= tmp_t[k];
      xfer(1'b1, 8'h18, {24'h0, cfg_t[k]});
      repeat (5) @(posedge clk);
      chk("final duty", {20'h0, exp_t[k]}, {20'h0, fduty[11:0]});
    end
    xfer(1'b0, 8'h88, 32'h0);
    chk("temperature", 32'hF6, rdata);
    load <= 3'b010;
    xfer(1'b1, 8'h58, 32'h10);
    repeat (3) @(posedge clk);
    chk("frozen duty", 32'h800, {20'h0, fduty[11:0]});
    chk("frozen flag", 32'h1, {31'h0, frozen});
    load <= 3'b000;
    repeat (3) @(posedge clk);
    chk("released duty", 32'h100, {20'h0, fduty[11:0]});
    results();
  end
endmodule // lcoc_test
